// >>> hw/sef_map.svh
// sef_map.svh: offsets, field positions, reset values and counts
// assumes byte addresses on a 32-bit register bus
`ifndef SEF_MAP_SVH
`define SEF_MAP_SVH
// register byte offsets
`define SEF_OFF_CTRL1 6'h00
`define SEF_OFF_CTRL2 6'h04
`define SEF_OFF_DIV 6'h0C
`define SEF_OFF_STAT 6'h10
`define SEF_OFF_DATA 6'h18
// control_first fields
`define SEF_C1_EN 0
`define SEF_C1_MODE_LSB 2
`define SEF_C1_EXT 5
`define SEF_C1_SRATE 13
// control_second fields
`define SEF_C2_CHW_LSB 0
`define SEF_C2_STOP 6
// status fields
`define SEF_ST_BUSY 0
`define SEF_ST_RXAV 1
`define SEF_ST_TXRDY 2
`define SEF_ST_TXIDLE 3
`define SEF_ST_OVF 4
`define SEF_ST_FERR 5
`define SEF_ST_RCNT_LSB 8
// divider layout and reset values
`define SEF_DIV_RST 16'h0000
`define SEF_FRAC_LSB 13
`define SEF_MODE_RST 3'h0
`define SEF_CHW_RST 3'h0
// mode code of the asynchronous serial port
`define SEF_MODE_UART 3'h1
// timing counts: disable delay in core clock cycles, bit phases in sample ticks
`define SEF_DIS_CYC 2
`define SEF_OVS_MID 4'h7
`define SEF_OVS_END 4'hF
`endif

// >>> hw/sef_pkg.sv
// sef_pkg: types of the serial framing engine
// assumes sef_map.svh holds all numeric constants
package sef_pkg;
    // control_first fields held in flops
    typedef struct packed {
        logic [2:0] mode;
        logic sample_rate_sel;
        logic ext_clk_sel;
    } sef_ctrl1_t;
    // control_second fields held in flops
    typedef struct packed {
        logic stop_bit_count_sel;
        logic [2:0] char_width_sel;
    } sef_ctrl2_t;
    // transmit and receive sequencers
    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} sef_tx_state_t;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sef_rx_state_t;
endpackage

// >>> hw/sef_fifo.sv
// sef_fifo: valid/ready FIFO with parameter width and depth
// assumes DEPTH is a power of two; same clock on both sides
`timescale 1ns/1ps
`default_nettype none
module sef_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 32
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // filling side
    input wire logic in_valid_in,
    input wire logic [W-1:0] in_data_in,
    output logic in_ready_out,
    // draining side
    output logic out_valid_out,
    output logic [W-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    wire logic push = in_valid_in && in_ready_out;
    wire logic pop = out_valid_out && out_ready_in;

    // honest full and empty from the fill count
    assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out = mem_q[rd_q];

    // storage, no reset needed for data words
    always_ff @(posedge clk_in) begin
        if (ce_in && push) begin
            mem_q[wr_q] <= in_data_in;
        end
    end

    // pointers and count
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else if (ce_in) begin
            wr_q <= push ? wr_q + AW'(1) : wr_q;
            rd_q <= pop ? rd_q + AW'(1) : rd_q;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // sef_fifo
`default_nettype wire

// >>> hw/sef_engine.sv
// sef_engine: framing, rate generation and registers of a serial port
// assumes an Avalon-MM master on clk_in; rxd and ext clock are async pins
//
// The Avalon-MM slave port is built into this module, with waitrequest on reads and on data writes to a full queue.
`timescale 1ns/1ps
`default_nettype none
`include "sef_map.svh"

// Functional notes
// R1: registers and shifters on core clock domain
// R2: one write buffer stage feeds shifter
// R3: receive shifter feeds two-entry buffer
// R4: rate source is core clock or external
// R5: software selects mode before enabling
// R6: stop select gives one or two stops
// R7: width codes give 8,9,5,6,7 bits
// R8: width and stop apply without sync handshake
// R9: arithmetic mode uses whole 16-bit divisor
// R10: fractional mode: top three bits fraction
// R11: divisor locked while enabled or access-locked
// R12: enabled writes dropped; disabling writes deferred
// R13: reserved width codes act as eight bits
module sef_engine #(
    parameter int FIFO_DEPTH = 32,
    parameter int DIS_CYC = `SEF_DIS_CYC
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // register bus
    input wire logic [5:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // write lock from the access controller
    input wire logic pac_wr_lock_in,
    // serial line and external rate clock
    input wire logic rxd_in,
    input wire logic ext_clk_in,
    output logic txd_out
);
    import sef_pkg::*;

    // data bits per character, reserved codes as eight
    function automatic logic [3:0] char_bits(input logic [2:0] w);
        unique case (w)
            3'h1: char_bits = 4'h9;
            3'h5: char_bits = 4'h5;
            3'h6: char_bits = 4'h6;
            3'h7: char_bits = 4'h7;
            default: char_bits = 4'h8; // see R7 see R13
        endcase
    endfunction

    // byte-lane merge of a bus write
    function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] be);
        for (int i = 0; i < 4; i++) begin
            be_merge[i*8 +: 8] = be[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
    endfunction

    // register state
    sef_ctrl1_t c1_q;
    sef_ctrl2_t c2_q;
    logic en_q;
    logic [15:0] div_q;
    logic [3:0] dcnt_q;
    logic pend_v_q;
    logic pend_div_q;
    logic [31:0] pend_data_q;
    logic rd_ack_q;
    logic [31:0] rdata_q;
    logic ovf_q;
    logic ferr_q;
    // rate generator state
    logic [1:0] ext_s_q;
    logic ext_prev_q;
    logic [15:0] acc_q;
    // transmit state
    logic hold_v_q;
    logic [8:0] hold_q;
    sef_tx_state_t tst_q;
    sef_tx_state_t tst_d;
    logic [3:0] tph_q;
    logic [3:0] tbit_q;
    logic [3:0] tbit_d;
    logic [8:0] tsh_q;
    logic [8:0] tsh_d;
    logic txd_q;
    logic txd_d;
    // receive state
    logic [1:0] rx_s_q;
    sef_rx_state_t rst_q;
    sef_rx_state_t rst_d;
    logic [3:0] rph_q;
    logic [3:0] rph_d;
    logic [3:0] rbit_q;
    logic [3:0] rbit_d;
    logic [8:0] rsh_q;
    logic [8:0] rsh_d;
    logic [8:0] rxb_q [2];
    logic [1:0] rcnt_q;
    logic rhead_q;
    // FIFO handshake
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [8:0] fifo_out_data;
    // register words
    logic [31:0] c1_word;
    logic [31:0] c2_word;
    logic [31:0] st_word;
    logic [31:0] rd_word;

    // address decode and bus handshake
    wire logic sel_c1 = (avs_address_in == `SEF_OFF_CTRL1);
    wire logic sel_c2 = (avs_address_in == `SEF_OFF_CTRL2);
    wire logic sel_div = (avs_address_in == `SEF_OFF_DIV);
    wire logic sel_st = (avs_address_in == `SEF_OFF_STAT);
    wire logic sel_data = (avs_address_in == `SEF_OFF_DATA);
    wire logic data_stall = avs_write_in && sel_data && !fifo_in_ready;
    assign avs_waitrequest_out = (avs_read_in && !rd_ack_q) || data_stall;
    assign avs_readdata_out = rdata_q;
    wire logic wr_hit = avs_write_in && !avs_waitrequest_out;
    wire logic rd_done = avs_read_in && rd_ack_q;
    wire logic [31:0] wd = avs_writedata_in;
    wire logic [3:0] be = avs_byteenable_in;

    // protected writes: dropped when enabled, deferred while disabling
    wire logic dis_busy = (dcnt_q != 4'h0);
    wire logic wr_c1 = wr_hit && sel_c1 && !pac_wr_lock_in;
    wire logic wr_c2 = wr_hit && sel_c2 && !pac_wr_lock_in;
    wire logic wr_div_raw = wr_hit && sel_div;
    wire logic wr_div = wr_div_raw && !pac_wr_lock_in; // see R11
    wire logic [31:0] c1_new = be_merge(c1_word, wd, be);
    wire logic new_en = c1_new[`SEF_C1_EN];
    wire logic prot_ok = !en_q && !dis_busy && !(wr_c1 && new_en); // see R12
    wire logic c1_apply = wr_c1 && prot_ok;
    wire logic div_apply = wr_div && prot_ok; // see R11
    wire logic pend_cap = (wr_c1 || wr_div) && dis_busy; // see R12
    wire logic pend_fire = pend_v_q && !dis_busy;
    wire logic go_dis = wr_c1 && en_q && !new_en;
    wire logic go_en = wr_c1 && !en_q && !dis_busy && new_en;
    wire logic [31:0] div_merged = be_merge({16'h0000, div_q}, wd, be);
    wire logic [31:0] c2_new = be_merge(c2_word, wd, be);

    // register read words
    always_comb begin
        c1_word = 32'h0000_0000;
        c1_word[`SEF_C1_EN] = en_q;
        c1_word[`SEF_C1_MODE_LSB +: 3] = c1_q.mode;
        c1_word[`SEF_C1_EXT] = c1_q.ext_clk_sel;
        c1_word[`SEF_C1_SRATE] = c1_q.sample_rate_sel;
        c2_word = 32'h0000_0000;
        c2_word[`SEF_C2_CHW_LSB +: 3] = c2_q.char_width_sel;
        c2_word[`SEF_C2_STOP] = c2_q.stop_bit_count_sel;
        st_word = 32'h0000_0000;
        st_word[`SEF_ST_BUSY] = dis_busy;
        st_word[`SEF_ST_RXAV] = (rcnt_q != 2'h0);
        st_word[`SEF_ST_TXRDY] = fifo_in_ready;
        st_word[`SEF_ST_TXIDLE] = (tst_q == TX_IDLE) && !hold_v_q;
        st_word[`SEF_ST_OVF] = ovf_q;
        st_word[`SEF_ST_FERR] = ferr_q;
        st_word[`SEF_ST_RCNT_LSB +: 2] = rcnt_q;
    end

    // read mux, unmapped addresses read zero
    assign rd_word = sel_c1 ? c1_word :
                     sel_c2 ? c2_word :
                     sel_div ? {16'h0000, div_q} :
                     sel_st ? st_word :
                     sel_data ? {23'h0, rxb_q[rhead_q]} : 32'h0000_0000;

    // engine runs only in the serial port mode
    wire logic run = en_q && (c1_q.mode == `SEF_MODE_UART); // see R5

    // control and divider registers on the core clock
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            en_q <= 1'b0;
            c1_q <= '{mode: `SEF_MODE_RST, sample_rate_sel: 1'b0, ext_clk_sel: 1'b0};
            c2_q <= '{stop_bit_count_sel: 1'b0, char_width_sel: `SEF_CHW_RST};
            div_q <= `SEF_DIV_RST; // see R9
            dcnt_q <= 4'h0;
            pend_v_q <= 1'b0;
            pend_div_q <= 1'b0;
            pend_data_q <= 32'h0000_0000;
        end else if (ce_in) begin // see R1
            en_q <= go_en ? 1'b1 : (go_dis ? 1'b0 : en_q);
            dcnt_q <= go_dis ? 4'(DIS_CYC) : (dis_busy ? dcnt_q - 4'h1 : dcnt_q);
            if (c1_apply || (pend_fire && !pend_div_q)) begin // see R12
                c1_q.mode <= c1_apply ? c1_new[`SEF_C1_MODE_LSB +: 3]
                                      : pend_data_q[`SEF_C1_MODE_LSB +: 3];
                c1_q.ext_clk_sel <= c1_apply ? c1_new[`SEF_C1_EXT] : pend_data_q[`SEF_C1_EXT];
                c1_q.sample_rate_sel <= c1_apply ? c1_new[`SEF_C1_SRATE]
                                                 : pend_data_q[`SEF_C1_SRATE];
            end
            if (wr_c2) begin // see R8
                c2_q.char_width_sel <= c2_new[`SEF_C2_CHW_LSB +: 3];
                c2_q.stop_bit_count_sel <= c2_new[`SEF_C2_STOP];
            end
            if (div_apply || (pend_fire && pend_div_q)) begin // see R11
                div_q <= div_apply ? div_merged[15:0] : pend_data_q[15:0];
            end
            pend_v_q <= pend_cap || (pend_v_q && dis_busy);
            if (pend_cap) begin
                pend_div_q <= wr_div;
                pend_data_q <= wr_div ? div_merged : c1_new;
            end
        end
    end

    // bus read answer one cycle after the request
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rd_ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (ce_in) begin
            rd_ack_q <= avs_read_in && !rd_ack_q;
            rdata_q <= (avs_read_in && !rd_ack_q) ? rd_word : rdata_q;
        end
    end

    // rate source: core clock or synchronised external edge
    wire logic ext_rise = ext_prev_q && !ext_s_q[1] ? 1'b0 : (ext_s_q[1] && !ext_prev_q);
    wire logic src_tick = c1_q.ext_clk_sel ? ext_rise : 1'b1; // see R4
    wire logic frac = c1_q.sample_rate_sel;
    wire logic [15:0] per_w = {div_q[12:0], 3'h0} + 16'(div_q[15:`SEF_FRAC_LSB]); // see R10
    wire logic [16:0] arith_sum = {1'b0, acc_q} + (17'h1_0000 - {1'b0, div_q}); // see R9
    wire logic [16:0] frac_sum = {1'b0, acc_q} + 17'h0_0008;
    wire logic frac_hit = (frac_sum >= {1'b0, per_w});
    wire logic smp_tick = run && src_tick && (frac ? frac_hit : arith_sum[16]);
    wire logic [16:0] frac_next = frac_hit ? frac_sum - {1'b0, per_w} : frac_sum;

    // rate generator accumulator at sixteen ticks per bit
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ext_s_q <= 2'h0;
            ext_prev_q <= 1'b0;
            acc_q <= 16'h0000;
        end else if (ce_in) begin
            ext_s_q <= {ext_s_q[0], ext_clk_in};
            ext_prev_q <= ext_s_q[1];
            if (!run) begin
                acc_q <= 16'h0000;
            end else if (src_tick) begin
                acc_q <= frac ? frac_next[15:0] : arith_sum[15:0];
            end
        end
    end

    // transmit path: FIFO, one write buffer stage, shifter
    wire logic tbit_end = smp_tick && (tph_q == `SEF_OVS_END);
    wire logic tx_load = (tst_q == TX_IDLE) && hold_v_q && smp_tick; // see R2
    wire logic fifo_pop = fifo_out_valid && !hold_v_q; // see R2
    wire logic data_push = wr_hit && sel_data;

    sef_fifo #(
        .W(9),
        .DEPTH(FIFO_DEPTH)
    ) u_tx_fifo (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .in_valid_in(data_push),
        .in_data_in(wd[8:0]),
        .in_ready_out(fifo_in_ready),
        .out_valid_out(fifo_out_valid),
        .out_data_out(fifo_out_data),
        .out_ready_in(!hold_v_q)
    );

    // transmit sequencer next state
    always_comb begin
        tst_d = tst_q;
        tbit_d = tbit_q;
        tsh_d = tsh_q;
        txd_d = txd_q;
        unique case (tst_q)
            TX_IDLE: begin
                txd_d = 1'b1;
                if (tx_load) begin
                    tst_d = TX_START;
                    tsh_d = hold_q;
                    txd_d = 1'b0;
                end
            end
            TX_START: if (tbit_end) begin
                tst_d = TX_DATA;
                tbit_d = char_bits(c2_q.char_width_sel); // see R7
                txd_d = tsh_q[0];
            end
            TX_DATA: if (tbit_end) begin
                tsh_d = tsh_q >> 1;
                tbit_d = tbit_q - 4'h1;
                txd_d = tsh_q[1];
                if (tbit_q == 4'h1) begin
                    tst_d = TX_STOP;
                    tbit_d = 4'h1 + {3'h0, c2_q.stop_bit_count_sel}; // see R6
                    txd_d = 1'b1;
                end
            end
            TX_STOP: if (tbit_end) begin
                tbit_d = tbit_q - 4'h1;
                if (tbit_q == 4'h1) begin
                    tst_d = TX_IDLE;
                end
            end
        endcase
        if (!run) begin
            tst_d = TX_IDLE;
            txd_d = 1'b1;
        end
    end

    // transmit flops
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            hold_v_q <= 1'b0;
            hold_q <= 9'h000;
            tst_q <= TX_IDLE;
            tph_q <= 4'h0;
            tbit_q <= 4'h0;
            tsh_q <= 9'h000;
            txd_q <= 1'b1;
        end else if (ce_in) begin
            hold_v_q <= fifo_pop || (hold_v_q && !tx_load);
            hold_q <= fifo_pop ? fifo_out_data : hold_q;
            tst_q <= tst_d;
            tph_q <= (tst_q == TX_IDLE) ? 4'h0 : (smp_tick ? tph_q + 4'h1 : tph_q);
            tbit_q <= tbit_d;
            tsh_q <= tsh_d;
            txd_q <= txd_d;
        end
    end
    assign txd_out = txd_q;

    // receive sequencer: start check at mid-bit, then one sample per bit
    wire logic rxs = rx_s_q[1];
    wire logic [3:0] rx_n = char_bits(c2_q.char_width_sel); // see R7
    wire logic rbit_end = smp_tick && (rph_q == `SEF_OVS_END);
    wire logic rx_push = (rst_q == RX_STOP) && rbit_end && rxs;
    wire logic ferr_set = (rst_q == RX_STOP) && rbit_end && !rxs;
    wire logic [8:0] rx_char = rsh_q >> (4'h9 - rx_n);
    wire logic rx_pop = rd_done && sel_data && (rcnt_q != 2'h0);
    wire logic rx_take = rx_push && ((rcnt_q != 2'h2) || rx_pop); // see R3
    wire logic ovf_set = rx_push && !rx_take;
    wire logic st_clr = wr_hit && sel_st;

    always_comb begin
        rst_d = rst_q;
        rph_d = smp_tick ? rph_q + 4'h1 : rph_q;
        rbit_d = rbit_q;
        rsh_d = rsh_q;
        unique case (rst_q)
            RX_IDLE: begin
                rph_d = 4'h0;
                if (smp_tick && !rxs) begin
                    rst_d = RX_START;
                end
            end
            RX_START: if (smp_tick && (rph_q == `SEF_OVS_MID)) begin
                rst_d = rxs ? RX_IDLE : RX_DATA;
                rph_d = 4'h0;
                rbit_d = rx_n;
            end
            RX_DATA: if (rbit_end) begin
                rsh_d = {rxs, rsh_q[8:1]};
                rbit_d = rbit_q - 4'h1;
                if (rbit_q == 4'h1) begin
                    rst_d = RX_STOP;
                end
            end
            RX_STOP: if (rbit_end) begin
                rst_d = RX_IDLE;
            end
        endcase
        if (!run) begin
            rst_d = RX_IDLE;
        end
    end

    // receive flops and two-entry buffer with sticky flags
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            rx_s_q <= 2'h3;
            rst_q <= RX_IDLE;
            rph_q <= 4'h0;
            rbit_q <= 4'h0;
            rsh_q <= 9'h000;
            rxb_q[0] <= 9'h000;
            rxb_q[1] <= 9'h000;
            rcnt_q <= 2'h0;
            rhead_q <= 1'b0;
            ovf_q <= 1'b0;
            ferr_q <= 1'b0;
        end else if (ce_in) begin
            rx_s_q <= {rx_s_q[0], rxd_in};
            rst_q <= rst_d;
            rph_q <= rph_d;
            rbit_q <= rbit_d;
            rsh_q <= rsh_d;
            if (rx_take) begin
                rxb_q[rhead_q ^ rcnt_q[0]] <= rx_char; // see R3
            end
            rcnt_q <= rcnt_q + {1'b0, rx_take} - {1'b0, rx_pop};
            rhead_q <= rx_pop ? !rhead_q : rhead_q;
            ovf_q <= ovf_set || (ovf_q && !(st_clr && be[0] && wd[`SEF_ST_OVF]));
            ferr_q <= ferr_set || (ferr_q && !(st_clr && be[0] && wd[`SEF_ST_FERR]));
        end
    end

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    sequence s_data_then_stop;
        (tst_q == TX_DATA) ##1 (tst_q == TX_STOP);
    endsequence

    AST_TX_ONE_STAGE: assert property (ce_in && hold_v_q && !tx_load |=> hold_v_q && $stable(hold_q)) // see R2
        else $error("write buffer lost its character");
    AST_RX_TWO: assert property (ce_in && rcnt_q == 2'h2 && rx_push && !rx_pop |=> rcnt_q == 2'h2 && ovf_q) // see R3
        else $error("receive buffer did not hold two");
    AST_EXT_SRC: assert property (c1_q.ext_clk_sel && !ext_rise |-> !smp_tick) // see R4
        else $error("tick without external edge");
    AST_STOP_LEN: assert property (s_data_then_stop |-> tbit_q == 4'h1 + {3'h0, $past(c2_q.stop_bit_count_sel)}) // see R6
        else $error("wrong stop bit count");
    AST_WIDTH: assert property (ce_in && tst_q == TX_START && tbit_end |=> tbit_q == char_bits($past(c2_q.char_width_sel))) // see R7
        else $error("wrong data bit count");
    AST_NO_SYNC: assert property (ce_in && wr_c2 && be[0] |=> c2_q.char_width_sel == $past(wd[2:0]) && !$rose(dis_busy)) // see R8
        else $error("width write not immediate");
    AST_ARITH: assert property (ce_in && run && !frac && src_tick && div_q == 16'h0000 |-> smp_tick) // see R9
        else $error("zero divisor must tick every source edge");
    AST_FRAC: assert property (ce_in && run && frac && src_tick && per_w > 16'h0008 |=> acc_q < $past(per_w)) // see R10
        else $error("fraction accumulator out of range");
    AST_DIV_LOCK: assert property (ce_in && wr_div_raw && (en_q || pac_wr_lock_in) // see R11
        && !pend_fire |=> $stable(div_q))
        else $error("divisor changed while protected");
    AST_DIS_PEND: assert property (ce_in && pend_fire && pend_div_q |=> div_q == $past(pend_data_q[15:0]) && !pend_v_q) // see R12
        else $error("deferred write not completed");
    AST_READ_ANS: assert property (ce_in && avs_read_in && !rd_ack_q |=> !avs_waitrequest_out || !avs_read_in)
        else $error("read not answered in one cycle");
endmodule // sef_engine
`default_nettype wire

// >>> bench/sef_remote.sv
// sef_remote: remote serial device on the line pins
// assumes divisor 0, so one bit lasts BIT core clocks
`timescale 1ns/1ps
`default_nettype none
module sef_remote #(parameter int BIT = 16) (
    // core clock and line pins
    input wire logic clk_in,
    input wire logic txd_in,
    output logic rxd_out
);
    int cyc = 0;
    // free cycle count for frame spacing
    always @(posedge clk_in) cyc <= cyc + 1;
    initial rxd_out = 1'b1;
    // start, n data bits lsb first, one stop; line idles high
    task automatic send(input logic [8:0] c, input int n);
        @(posedge clk_in);
        rxd_out <= 1'b0;
        for (int i = 0; i <= n; i++) begin
            repeat (BIT) @(posedge clk_in);
            rxd_out <= (i == n) ? 1'b1 : c[i];
        end
        repeat (BIT) @(posedge clk_in);
    endtask
    // waits for a start bit, samples each bit in its middle
    task automatic grab(input int n, output logic [8:0] c, output int t0, output logic ok);
        c = '0;
        while (txd_in === 1'b1) @(posedge clk_in);
        t0 = cyc;
        repeat (BIT / 2) @(posedge clk_in);
        ok = (txd_in === 1'b0);
        for (int i = 0; i < n; i++) begin
            repeat (BIT) @(posedge clk_in);
            c[i] = txd_in;
        end
        repeat (BIT) @(posedge clk_in);
        ok = ok && (txd_in === 1'b1);
    endtask
endmodule // sef_remote
`default_nettype wire

// >>> bench/sef_bench.sv
// sef bench: self-checking run of the serial engine
// assumes divisor 0 in line tests, so one bit is 16 core clocks
`timescale 1ns/1ps
`default_nettype none
`include "sef_map.svh"
module serial_engine_frame_and_rate_bench;
    import sef_pkg::*;
    logic clk = 0, nrst = 0, rd_s = 0, wr_s = 0, lock = 0, extc = 0;
    logic [5:0] adr = '0;
    logic [31:0] wdat = '0, rdat, d;
    logic wreq, rxd, txd, ok, ok2;
    logic [8:0] c1, c2;
    int error_cnt = 0, n_checks = 0, t0, t1;
    // core clock 4 ns, free external rate pin
    always #2 clk = ~clk;
    always #10 extc <= ~extc;
    sef_engine #(.FIFO_DEPTH(32), .DIS_CYC(6)) dut (.clk_in(clk), .nrst_in(nrst),
        .ce_in(1'b1), .avs_address_in(adr), .avs_read_in(rd_s), .avs_write_in(wr_s),
        .avs_writedata_in(wdat), .avs_byteenable_in(4'hF), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .pac_wr_lock_in(lock), .rxd_in(rxd),
        .ext_clk_in(extc), .txd_out(txd));
    sef_remote u_rem (.clk_in(clk), .txd_in(txd), .rxd_out(rxd));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one bus access, held until waitrequest is low
    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] v);
        @(posedge clk);
        adr <= a;
        wdat <= v;
        wr_s <= w;
        rd_s <= !w;
        do @(posedge clk); while (wreq !== 1'b0);
        d = rdat;
        wr_s <= 1'b0;
        rd_s <= 1'b0;
    endtask
    task automatic rchk(input logic [5:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        chk(d, e);
    endtask
    // reset values, unmapped place, divisor locks, deferred write
    task automatic t_regs;
        rchk(`SEF_OFF_DIV, 32'h0000);
        rchk(`SEF_OFF_STAT, 32'h000C);
        rchk(6'h3C, 32'h0);
        acc(1'b1, `SEF_OFF_DIV, 32'hA5C3);
        rchk(`SEF_OFF_DIV, 32'hA5C3);
        lock <= 1'b1;
        acc(1'b1, `SEF_OFF_DIV, 32'h1234);
        lock <= 1'b0;
        rchk(`SEF_OFF_DIV, 32'hA5C3);
        acc(1'b1, `SEF_OFF_CTRL1, 32'h5);
        acc(1'b1, `SEF_OFF_DIV, 32'h7777);
        rchk(`SEF_OFF_DIV, 32'hA5C3);
        acc(1'b1, `SEF_OFF_CTRL1, 32'h4);
        acc(1'b1, `SEF_OFF_DIV, 32'h0000);
        rchk(`SEF_OFF_DIV, 32'hA5C3);
        repeat (8) @(posedge clk);
        rchk(`SEF_OFF_DIV, 32'h0000);
        acc(1'b1, `SEF_OFF_CTRL1, 32'h4);
        acc(1'b1, `SEF_OFF_CTRL1, 32'h5);
    endtask
    // width codes 0, 1, 5, 6, 7 and reserved 3, both stop counts, two characters back to back
    task automatic t_tx;
        logic [2:0] code [6] = '{3'h0, 3'h1, 3'h5, 3'h6, 3'h7, 3'h3};
        int nb [6] = '{8, 9, 5, 6, 7, 8};
        logic [8:0] m;
        for (int k = 0; k < 6; k++) begin
            m = 9'h1FF >> (9 - nb[k]);
            acc(1'b1, `SEF_OFF_CTRL2, {25'h0, k[0], 3'h0, code[k]});
            fork
                begin
                    u_rem.grab(nb[k], c1, t0, ok);
                    u_rem.grab(nb[k], c2, t1, ok2);
                end
                begin
                    acc(1'b1, `SEF_OFF_DATA, 32'h1A5);
                    acc(1'b1, `SEF_OFF_DATA, 32'h05A);
                end
            join
            chk({c1, c2, ok, ok2}, {9'h1A5 & m, 9'h05A & m, 2'b11});
            chk(32'((t1 - t0 - (2 + nb[k] + k % 2) * 16) inside {[0:2]}), 32'h1);
        end
    endtask
    // fill the transmit queue past refusal, drain it in order
    task automatic t_fill;
        fork
            for (int i = 0; i < 36; i++) acc(1'b1, `SEF_OFF_DATA, 32'(i));
            for (int j = 0; j < 36; j++) begin
                u_rem.grab(8, c1, t0, ok);
                chk({23'h0, c1}, 32'(j));
            end
        join
    endtask
    // three characters with none read: third lost and flagged
    task automatic t_rx;
        acc(1'b1, `SEF_OFF_CTRL2, 32'h0);
        u_rem.send(9'h03C, 8);
        u_rem.send(9'h0C3, 8);
        u_rem.send(9'h05A, 8);
        rchk(`SEF_OFF_STAT, 32'h021E);
        rchk(`SEF_OFF_DATA, 32'h003C);
        rchk(`SEF_OFF_DATA, 32'h00C3);
        acc(1'b1, `SEF_OFF_STAT, 32'h10);
        rchk(`SEF_OFF_STAT, 32'h000C);
    endtask
    // disable, set divisor and source, enable, time one start bit in clocks
    task automatic t_rate(input logic [15:0] dv, input logic [31:0] cw, input int lo,
                          input int hi);
        int n = 0;
        acc(1'b1, `SEF_OFF_CTRL1, 32'h4);
        repeat (8) @(posedge clk);
        acc(1'b1, `SEF_OFF_DIV, {16'h0, dv});
        acc(1'b1, `SEF_OFF_CTRL1, cw);
        acc(1'b1, `SEF_OFF_CTRL1, cw | 32'h1);
        acc(1'b1, `SEF_OFF_DATA, 32'h0FF);
        while (txd !== 1'b0) @(posedge clk);
        while (txd === 1'b0) begin
            n++;
            @(posedge clk);
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // reset for six cycles, then the scenarios
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_regs;
        t_tx;
        t_fill;
        t_rx;
        t_rate(16'h8002, 32'h2004, 39, 41);
        t_rate(16'h0000, 32'h0024, 79, 81);
        finish_test;
    end
    // watchdog well beyond the expected run
    initial begin
        #200000;
        error_cnt++;
        finish_test;
    end
endmodule // serial_engine_frame_and_rate_bench
`default_nettype wire
